// ### synth_ctrl_pkg.sv
package synth_ctrl_pkg;
    // Register addresses on the core register bus
    localparam logic [7:0] MODE_ADDR = 8'hF8;
    localparam logic [7:0] REF_ADDR = 8'hF9;
    // Mode register fields
    localparam int MODE_DIV_BIT = 7;
    localparam int MODE_RUN_BIT = 6;
    localparam int MODE_SWALLOW_LSB_BIT = 5;
    localparam int MODE_UNUSED_BIT = 4;
    localparam int MODE_IF_EN_BIT = 3;
    localparam int MODE_IF_PEND_BIT = 2;
    localparam int MODE_CE_EN_BIT = 1;
    localparam int MODE_CE_PEND_BIT = 0;
    localparam logic [3:0] MODE_UPPER_RESET = 4'h0;
    // Reference register fields
    localparam int REF_LOCK_BIT = 7;
    localparam int REF_CE_BIT = 6;
    localparam int REF_GATE_BIT = 5;
    localparam int REF_POWER_FLAG_BIT = 4;
    localparam logic [3:0] REF_SEL_MAX = 4'h9;
    localparam logic [3:0] REF_SEL_RESET = 4'h0;
endpackage

// ### sync2.sv
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    if (WIDTH < 1) begin : g_bad_width
        $error("sync2 width must be at least 1");
    end

    always_ff @(posedge clk_i) begin
        meta_reg <= async_i;
        sync_reg <= meta_reg;
    end

    assign sync_o = sync_reg;
endmodule
`default_nettype wire

// ### pll_synth_control_status.sv
// Notes on behaviour
// - Mode bit 7 selects direct division at 0 and pulse-swallow division at 1.
// - Mode bit 6 stops the synthesizer at 0 and runs it at 1.
// - Mode bit 5 is the value loaded into the swallow counter's least significant bit.
// - Mode bit 3 gates IF counter interrupt requests to the core.
// - Mode bit 2 reads 1 while an IF counter request pends and a written 0 clears it.
// - Mode bit 1 gates chip-enable pin interrupt requests to the core.
// - Mode bit 0 reads 1 while a chip-enable request pends and a written 0 clears it.
// - Mode upper four bits reset to 0 while the lower bits keep their value over reset.
// - Reference bit 5 reads 0 while the IF counter gate is open and 1 while closed.
// - The power-on flag reads 1 after power-on and survives a system reset.
`timescale 1ns/10ps
`default_nettype none
module pll_synth_control_status (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic power_on_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic unlocked_i,
    input wire logic chip_enable_pin_i,
    input wire logic if_gate_closed_i,
    input wire logic if_count_done_i,
    output logic pulse_swallow_o,
    output logic synth_run_o,
    output logic swallow_lsb_value_o,
    output logic [3:0] ref_select_o,
    output logic if_counter_irq_o,
    output logic chip_enable_pin_irq_o
);
    logic [2:0] pins_sync;
    logic ce_prev_reg;
    logic ce_prev_next;
    logic [7:0] synth_mode_reg;
    logic [7:0] synth_mode_next;
    logic power_up_flag_reg;
    logic power_up_flag_next;
    logic [3:0] ref_sel_reg;
    logic [3:0] ref_sel_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic ce_event;
    logic wr_mode;
    logic wr_ref;
    logic [7:0] status_byte;

    sync2 #(.WIDTH(3)) pin_sync (
        .clk_i(clk_i),
        .async_i({chip_enable_pin_i, if_gate_closed_i, unlocked_i}),
        .sync_o(pins_sync)
    );

    assign ce_event = pins_sync[2] & ~ce_prev_reg;
    assign wr_mode = reg_wr_i && (reg_addr_i == synth_ctrl_pkg::MODE_ADDR);
    assign wr_ref = reg_wr_i && (reg_addr_i == synth_ctrl_pkg::REF_ADDR);

    always_comb begin
        status_byte = {pins_sync[0], pins_sync[2], pins_sync[1], power_up_flag_reg,
            ref_sel_reg};
        synth_mode_next = synth_mode_reg;
        ref_sel_next = ref_sel_reg;
        power_up_flag_next = power_up_flag_reg;
        ce_prev_next = pins_sync[2];
        rdata_next = rdata_reg;
        if (wr_mode) begin
            synth_mode_next[synth_ctrl_pkg::MODE_DIV_BIT] =
                reg_wdata_i[synth_ctrl_pkg::MODE_DIV_BIT];
            synth_mode_next[synth_ctrl_pkg::MODE_RUN_BIT] =
                reg_wdata_i[synth_ctrl_pkg::MODE_RUN_BIT];
            synth_mode_next[synth_ctrl_pkg::MODE_SWALLOW_LSB_BIT] =
                reg_wdata_i[synth_ctrl_pkg::MODE_SWALLOW_LSB_BIT];
            synth_mode_next[synth_ctrl_pkg::MODE_UNUSED_BIT] = 1'b0;
            synth_mode_next[synth_ctrl_pkg::MODE_IF_EN_BIT] =
                reg_wdata_i[synth_ctrl_pkg::MODE_IF_EN_BIT];
            synth_mode_next[synth_ctrl_pkg::MODE_CE_EN_BIT] =
                reg_wdata_i[synth_ctrl_pkg::MODE_CE_EN_BIT];
            if (!reg_wdata_i[synth_ctrl_pkg::MODE_IF_PEND_BIT]) begin
                synth_mode_next[synth_ctrl_pkg::MODE_IF_PEND_BIT] = 1'b0;
            end
            if (!reg_wdata_i[synth_ctrl_pkg::MODE_CE_PEND_BIT]) begin
                synth_mode_next[synth_ctrl_pkg::MODE_CE_PEND_BIT] = 1'b0;
            end
        end
        // Set wins over a clearing write in the same cycle
        if (if_count_done_i) begin
            synth_mode_next[synth_ctrl_pkg::MODE_IF_PEND_BIT] = 1'b1;
        end
        if (ce_event) begin
            synth_mode_next[synth_ctrl_pkg::MODE_CE_PEND_BIT] = 1'b1;
        end
        if (wr_ref) begin
            if (reg_wdata_i[3:0] <= synth_ctrl_pkg::REF_SEL_MAX) begin
                ref_sel_next = reg_wdata_i[3:0];
            end
            if (!reg_wdata_i[synth_ctrl_pkg::REF_POWER_FLAG_BIT]) begin
                power_up_flag_next = 1'b0;
            end
        end
        if (reg_rd_i) begin
            if (reg_addr_i == synth_ctrl_pkg::MODE_ADDR) begin
                rdata_next = synth_mode_reg;
            end else if (reg_addr_i == synth_ctrl_pkg::REF_ADDR) begin
                rdata_next = status_byte;
            end else begin
                rdata_next = 8'h00;
            end
        end
        // Power-on clears mode and code and sets the flag; system reset keeps low mode bits, code and flag
        if (power_on_i) begin
            synth_mode_next = 8'h00;
            power_up_flag_next = 1'b1;
            ref_sel_next = synth_ctrl_pkg::REF_SEL_RESET;
        end else if (sys_rst_i) begin
            synth_mode_next = {synth_ctrl_pkg::MODE_UPPER_RESET,
                synth_mode_reg[3:0]};
            power_up_flag_next = power_up_flag_reg;
            ref_sel_next = ref_sel_reg;
        end
    end

    // Outputs load the same value as the registers, so they never disagree
    always_ff @(posedge clk_i) begin
        ce_prev_reg <= ce_prev_next;
        rdata_reg <= rdata_next;
        synth_mode_reg <= synth_mode_next;
        power_up_flag_reg <= power_up_flag_next;
        ref_sel_reg <= ref_sel_next;
        pulse_swallow_o <= synth_mode_next[synth_ctrl_pkg::MODE_DIV_BIT];
        synth_run_o <= synth_mode_next[synth_ctrl_pkg::MODE_RUN_BIT];
        swallow_lsb_value_o <= synth_mode_next[synth_ctrl_pkg::MODE_SWALLOW_LSB_BIT];
        ref_select_o <= ref_sel_next;
        if_counter_irq_o <= synth_mode_next[synth_ctrl_pkg::MODE_IF_EN_BIT]
            & synth_mode_next[synth_ctrl_pkg::MODE_IF_PEND_BIT];
        chip_enable_pin_irq_o <= synth_mode_next[synth_ctrl_pkg::MODE_CE_EN_BIT]
            & synth_mode_next[synth_ctrl_pkg::MODE_CE_PEND_BIT];
    end
    assign reg_rdata_o = rdata_reg;

    // Control outputs
    run_follows_a: assert property (@(posedge clk_i)
        disable iff (sys_rst_i || power_on_i)
        $past(wr_mode) && !$past(sys_rst_i) && !$past(power_on_i)
        |-> synth_run_o == $past(reg_wdata_i[synth_ctrl_pkg::MODE_RUN_BIT]))
        else $error("run output does not follow write");
    div_follows_a: assert property (@(posedge clk_i)
        disable iff (sys_rst_i || power_on_i)
        pulse_swallow_o == synth_mode_reg[synth_ctrl_pkg::MODE_DIV_BIT])
        else $error("division output mismatch");
    lsb_follows_a: assert property (@(posedge clk_i)
        disable iff (sys_rst_i || power_on_i)
        swallow_lsb_value_o == synth_mode_reg[synth_ctrl_pkg::MODE_SWALLOW_LSB_BIT])
        else $error("swallow bit output mismatch");
    run_reset_a: assert property (@(posedge clk_i)
        disable iff (power_on_i)
        sys_rst_i |=> !synth_run_o && !pulse_swallow_o && !swallow_lsb_value_o)
        else $error("control outputs not cleared by reset");

    // Interrupt sources
    if_irq_gate_a: assert property (@(posedge clk_i)
        disable iff (sys_rst_i || power_on_i)
        if_counter_irq_o == (synth_mode_reg[3] && synth_mode_reg[2]))
        else $error("IF irq gating wrong");
    if_pend_set_a: assert property (@(posedge clk_i)
        disable iff (sys_rst_i || power_on_i)
        if_count_done_i |=> synth_mode_reg[2])
        else $error("IF pending not set");
    if_pend_clear_a: assert property (@(posedge clk_i)
        disable iff (sys_rst_i || power_on_i)
        wr_mode && !reg_wdata_i[2] && !if_count_done_i |=> !synth_mode_reg[2])
        else $error("IF pending not cleared");
    ce_irq_gate_a: assert property (@(posedge clk_i)
        disable iff (sys_rst_i || power_on_i)
        chip_enable_pin_irq_o == (synth_mode_reg[1] && synth_mode_reg[0]))
        else $error("CE irq gating wrong");
    ce_pend_set_a: assert property (@(posedge clk_i)
        disable iff (sys_rst_i || power_on_i)
        ce_event |=> synth_mode_reg[0])
        else $error("CE pending not set");
    ce_pend_clear_a: assert property (@(posedge clk_i)
        disable iff (sys_rst_i || power_on_i)
        wr_mode && !reg_wdata_i[0] && !ce_event |=> !synth_mode_reg[0])
        else $error("CE pending not cleared");

    // Mode register and power flag
    mode_reset_a: assert property (@(posedge clk_i)
        disable iff (power_on_i)
        sys_rst_i |=> synth_mode_reg[7:4] == 4'h0
            && synth_mode_reg[3:0] == $past(synth_mode_reg[3:0]))
        else $error("mode reset wrong");
    unused_zero_a: assert property (@(posedge clk_i)
        disable iff (power_on_i)
        synth_mode_reg[synth_ctrl_pkg::MODE_UNUSED_BIT] == 1'b0)
        else $error("unused mode bit set");
    mode_read_a: assert property (@(posedge clk_i)
        disable iff (power_on_i)
        $past(reg_rd_i && (reg_addr_i == synth_ctrl_pkg::MODE_ADDR))
        |-> reg_rdata_o == $past(synth_mode_reg))
        else $error("mode read data wrong");
    pof_keep_a: assert property (@(posedge clk_i)
        disable iff (power_on_i)
        sys_rst_i |=> power_up_flag_reg == $past(power_up_flag_reg))
        else $error("power flag lost on reset");
    pof_power_a: assert property (@(posedge clk_i)
        power_on_i |=> power_up_flag_reg)
        else $error("power flag not set by power-on");
    pof_clear_a: assert property (@(posedge clk_i)
        disable iff (sys_rst_i || power_on_i)
        wr_ref && !reg_wdata_i[synth_ctrl_pkg::REF_POWER_FLAG_BIT] |=> !power_up_flag_reg)
        else $error("power flag not cleared");

    // Reference register
    status_read_a: assert property (@(posedge clk_i)
        disable iff (power_on_i)
        $past(reg_rd_i && (reg_addr_i == synth_ctrl_pkg::REF_ADDR))
        |-> reg_rdata_o[7:5] == $past({pins_sync[0], pins_sync[2], pins_sync[1]}))
        else $error("status read data wrong");
    ref_code_a: assert property (@(posedge clk_i)
        disable iff (sys_rst_i || power_on_i)
        ref_sel_reg <= synth_ctrl_pkg::REF_SEL_MAX)
        else $error("unused reference code held");
    ref_load_a: assert property (@(posedge clk_i)
        disable iff (sys_rst_i || power_on_i)
        wr_ref && (reg_wdata_i[3:0] <= synth_ctrl_pkg::REF_SEL_MAX)
        |=> ref_sel_reg == $past(reg_wdata_i[3:0]))
        else $error("reference code not loaded");
    ref_hold_a: assert property (@(posedge clk_i)
        disable iff (sys_rst_i || power_on_i)
        wr_ref && (reg_wdata_i[3:0] > synth_ctrl_pkg::REF_SEL_MAX)
        |=> ref_sel_reg == $past(ref_sel_reg))
        else $error("unused reference code taken");
    ref_out_a: assert property (@(posedge clk_i)
        disable iff (sys_rst_i || power_on_i)
        ref_select_o == ref_sel_reg)
        else $error("reference output mismatch");
endmodule
`default_nettype wire

// ### synth_far_side.sv
`timescale 1ns/10ps
`default_nettype none
module synth_far_side (
    input wire logic clk_i,
    input wire logic ce_cmd_i,
    input wire logic unlock_cmd_i,
    input wire logic gate_cmd_i,
    input wire logic count_cmd_i,
    output logic ce_pin_o,
    output logic unlocked_o,
    output logic gate_closed_o,
    output logic count_done_o
);
    // Pin levels move just after an edge; the count event lasts one cycle
    always_ff @(posedge clk_i) begin
        ce_pin_o <= ce_cmd_i;
        unlocked_o <= unlock_cmd_i;
        gate_closed_o <= gate_cmd_i;
        count_done_o <= count_cmd_i;
    end
endmodule
`default_nettype wire

// ### pll_synth_control_status_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module pll_synth_control_status_tb_top;
    logic clk, sys_rst, pwr, wr, rd, ce_cmd, unl_cmd, gate_cmd, cnt_cmd;
    logic ce_pin, unl, gate, cnt, ps, run, lsb, ifirq, ceirq;
    logic [7:0] addr, wdata, rdata, d;
    logic [3:0] refsel;
    int n_errors = 0;
    int check_count = 0;
    synth_far_side far (.clk_i(clk), .ce_cmd_i(ce_cmd), .unlock_cmd_i(unl_cmd),
        .gate_cmd_i(gate_cmd), .count_cmd_i(cnt_cmd), .ce_pin_o(ce_pin),
        .unlocked_o(unl), .gate_closed_o(gate), .count_done_o(cnt));
    pll_synth_control_status dut (.clk_i(clk), .sys_rst_i(sys_rst), .power_on_i(pwr),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .unlocked_i(unl), .chip_enable_pin_i(ce_pin),
        .if_gate_closed_i(gate), .if_count_done_i(cnt), .pulse_swallow_o(ps),
        .synth_run_o(run), .swallow_lsb_value_o(lsb), .ref_select_o(refsel),
        .if_counter_irq_o(ifirq), .chip_enable_pin_irq_o(ceirq));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            n_errors++;
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic sys_reset();
        @(posedge clk);
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic test_power_on();
        rd_reg(8'hF9); chk("ref after power-on", 8'h10, d);
        rd_reg(8'hF8); chk("mode after power-on", 8'h00, d);
        rd_reg(8'h00); chk("unmapped read", 8'h00, d);
        $display("test power-on done");
    endtask
    task automatic test_mode();
        wr_reg(8'hF8, 8'hC8); chk("div run lsb", 8'h06, {5'h00, ps, run, lsb});
        rd_reg(8'hF8); chk("mode readback", 8'hC8, d);
        wr_reg(8'hF8, 8'h20); chk("lsb only", 8'h01, {5'h00, ps, run, lsb});
        $display("test mode done");
    endtask
    task automatic test_if_irq();
        wr_reg(8'hF8, 8'h08);
        @(posedge clk);
        cnt_cmd <= 1'b1;
        @(posedge clk);
        cnt_cmd <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk("if irq enabled", 8'h01, {7'h00, ifirq});
        rd_reg(8'hF8); chk("if pending", 8'h0C, d);
        wr_reg(8'hF8, 8'h04); #5 chk("if irq masked", 8'h00, {7'h00, ifirq});
        wr_reg(8'hF8, 8'h00); rd_reg(8'hF8); chk("if cleared", 8'h00, d);
        // Event and clearing write reach the block at the same edge
        @(posedge clk);
        cnt_cmd <= 1'b1;
        @(posedge clk);
        cnt_cmd <= 1'b0;
        addr <= 8'hF8;
        wdata <= 8'h00;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        rd_reg(8'hF8); chk("set beats clear", 8'h04, d);
        wr_reg(8'hF8, 8'h00);
        $display("test if irq done");
    endtask
    task automatic test_ce_irq();
        wr_reg(8'hF8, 8'h02);
        @(posedge clk);
        ce_cmd <= 1'b1;
        repeat (8) @(posedge clk);
        #1 chk("ce irq", 8'h01, {7'h00, ceirq});
        rd_reg(8'hF8); chk("ce pending", 8'h03, d);
        rd_reg(8'hF9); chk("ce level", 8'h50, d);
        wr_reg(8'hF8, 8'h02); #5 chk("ce irq cleared", 8'h00, {7'h00, ceirq});
        @(posedge clk);
        ce_cmd <= 1'b0;
        $display("test ce irq done");
    endtask
    task automatic test_status();
        @(posedge clk);
        unl_cmd <= 1'b1;
        gate_cmd <= 1'b1;
        repeat (6) @(posedge clk);
        rd_reg(8'hF9); chk("unlock gate", 8'hB0, d);
        @(posedge clk);
        unl_cmd <= 1'b0;
        gate_cmd <= 1'b0;
        wr_reg(8'hF9, 8'h19); chk("ref code 9", 8'h09, {4'h0, refsel});
        wr_reg(8'hF9, 8'h1A); chk("ref code A", 8'h09, {4'h0, refsel});
        $display("test status done");
    endtask
    task automatic test_sys_reset();
        wr_reg(8'hF8, 8'hEA);
        sys_reset();
        rd_reg(8'hF8); chk("mode after reset", 8'h0A, d);
        rd_reg(8'hF9); chk("ref after reset", 8'h19, d);
        wr_reg(8'hF9, 8'h09);
        sys_reset();
        rd_reg(8'hF9); chk("flag stays clear", 8'h09, d);
        $display("test system reset done");
    endtask
    initial begin
        {sys_rst, pwr, wr, rd, ce_cmd, unl_cmd, gate_cmd, cnt_cmd} = 8'hFF & 8'hC0;
        addr = 8'h00;
        wdata = 8'h00;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        pwr <= 1'b0;
        test_power_on();
        test_mode();
        test_if_irq();
        test_ce_irq();
        test_status();
        test_sys_reset();
        final_report();
    end
endmodule
`default_nettype wire
